// *** core/ext_irq_detect.sv ***
// one source: pin synchroniser and sense-selected request detection
`timescale 1ns/10ps
module ext_irq_detect (
	input wire logic clk,
	input wire logic resetn,
	input wire logic pinN,
	input wire ext_irq_pkg::sense_t sense,
	output logic hit
);
	logic syncA_r;
	logic syncB_r;
	logic prev_r;
	logic fall;
	logic rise;

	// first stage feeds only the second; edges use the second stage
	always_ff @(posedge clk) begin
		if (!resetn) begin
			syncA_r <= 1'b1;
			syncB_r <= 1'b1;
			prev_r <= 1'b1;
		end else begin
			syncA_r <= pinN;
			syncB_r <= syncA_r;
			prev_r <= syncB_r;
		end
	end

	assign fall = prev_r & ~syncB_r;
	assign rise = ~prev_r & syncB_r;

	always_comb begin
		unique case (sense)
			ext_irq_pkg::SENSE_LOW_LEVEL: hit = ~syncB_r;
			ext_irq_pkg::SENSE_FALLING: hit = fall;
			ext_irq_pkg::SENSE_RISING: hit = rise;
			ext_irq_pkg::SENSE_BOTH: hit = fall | rise;
		endcase
	end
endmodule : ext_irq_detect

// *** core/ext_irq_enable_sense.sv ***
// top: enable and sense registers, request flags, forwarded requests and event interrupt
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/10ps
module ext_irq_enable_sense #(
	parameter int NSRC = ext_irq_pkg::NUM_SRC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [NSRC-1:0] extReqPinN,
	input wire logic [ext_irq_pkg::ADDR_W-1:0] addr,
	input wire logic [ext_irq_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [ext_irq_pkg::DATA_W-1:0] rdata,
	output logic [NSRC-1:0] srcReq,
	output logic irq
);
	localparam int DW = ext_irq_pkg::DATA_W;
	localparam int EW = ext_irq_pkg::EVT_W;

	ext_irq_pkg::bus_req_t bus;
	logic [DW-1:0] enable_r;
	logic [DW-1:0] senseHigh_r;
	logic [DW-1:0] senseLow_r;
	logic [NSRC-1:0] flags_r;
	logic [NSRC-1:0] flags_nxt;
	logic [NSRC-1:0] hit;
	logic [NSRC-1:0] flagClr;
	logic [EW-1:0] evtStatus_r;
	logic [EW-1:0] evtEnable_r;
	logic [EW-1:0] evt;
	logic [EW-1:0] evtClr;
	logic [DW-1:0] rdata_r;
	logic [NSRC-1:0] srcReq_r;
	logic irq_r;
	logic [2*NSRC-1:0] senseAll;

	assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
	// both sense words joined: high word holds sources 15..8, low word 7..0
	assign senseAll = {senseHigh_r, senseLow_r};

	genvar gi;
	generate
		for (gi = 0; gi < NSRC; gi++) begin : g_src
			ext_irq_detect u_det (
				.clk(clk),
				.resetn(resetn),
				.pinN(extReqPinN[gi]),
				.sense(ext_irq_pkg::sense_t'(senseAll[gi*ext_irq_pkg::SENSE_W +: ext_irq_pkg::SENSE_W])),
				.hit(hit[gi])
			);
		end
	endgenerate

	// register writes
	always_ff @(posedge clk) begin
		if (!resetn) begin
			enable_r <= ext_irq_pkg::RESET_WORD;
			senseHigh_r <= ext_irq_pkg::RESET_WORD;
			senseLow_r <= ext_irq_pkg::RESET_WORD;
			evtEnable_r <= '0;
		end else if (bus.wr) begin
			unique case (bus.addr)
				ext_irq_pkg::OFF_ENABLE: enable_r <= bus.wdata;
				ext_irq_pkg::OFF_SENSE_HIGH: senseHigh_r <= bus.wdata;
				ext_irq_pkg::OFF_SENSE_LOW: senseLow_r <= bus.wdata;
				ext_irq_pkg::OFF_IRQ_ENABLE: evtEnable_r <= bus.wdata[EW-1:0];
				default: ;
			endcase
		end
	end

	assign flagClr = (bus.wr && bus.addr == ext_irq_pkg::OFF_FLAG_CLEAR) ? bus.wdata[NSRC-1:0] : '0;
	assign evtClr = (bus.wr && bus.addr == ext_irq_pkg::OFF_IRQ_CLEAR) ? bus.wdata[EW-1:0] : '0;
	// set wins over a same-cycle clear so no edge is lost
	assign flags_nxt = (flags_r & ~flagClr) | hit;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			flags_r <= '0;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// events: a flag newly set, and a hit on an already-set flag not cleared that cycle (overrun)
	assign evt[ext_irq_pkg::EVT_FLAG_SET] = |(hit & ~flags_r);
	assign evt[ext_irq_pkg::EVT_OVERRUN] = |(hit & flags_r & ~flagClr);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			evtStatus_r <= '0;
		end else begin
			evtStatus_r <= (evtStatus_r & ~evtClr) | evt;
		end
	end

	// forwarded requests and interrupt are registered from next state
	always_ff @(posedge clk) begin
		if (!resetn) begin
			srcReq_r <= '0;
			irq_r <= 1'b0;
		end else begin
			srcReq_r <= flags_nxt & enable_r[NSRC-1:0];
			irq_r <= |(((evtStatus_r & ~evtClr) | evt) & evtEnable_r);
		end
	end

	// read data valid only in the cycle after the read strobe
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata_r <= '0;
		end else if (bus.rd) begin
			unique case (bus.addr)
				ext_irq_pkg::OFF_ENABLE: rdata_r <= enable_r;
				ext_irq_pkg::OFF_SENSE_HIGH: rdata_r <= senseHigh_r;
				ext_irq_pkg::OFF_SENSE_LOW: rdata_r <= senseLow_r;
				ext_irq_pkg::OFF_FLAGS: rdata_r <= DW'(flags_r);
				ext_irq_pkg::OFF_IRQ_STATUS: rdata_r <= DW'(evtStatus_r);
				ext_irq_pkg::OFF_IRQ_ENABLE: rdata_r <= DW'(evtEnable_r);
				default: rdata_r <= '0;
			endcase
		end else begin
			rdata_r <= '0;
		end
	end

	assign rdata = rdata_r;
	assign srcReq = srcReq_r;
	assign irq = irq_r;

	// reset: registers, flags and every output start cleared
	a_reset_enable: assert property (@(posedge clk)
		!resetn |=> enable_r == '0 && senseHigh_r == '0)
		else $error("enable or sense not cleared by reset");

	a_reset_outputs: assert property (@(posedge clk)
		!resetn |=> rdata == '0 && srcReq == '0 && !irq && flags_r == '0)
		else $error("outputs or flags not cleared by reset");

	a_reset_low: assert property (@(posedge clk)
		!resetn |=> senseLow_r == '0)
		else $error("low sense not cleared by reset");

	// register port: writes land next cycle, other cycles leave words alone
	a_enable_write: assert property (@(posedge clk) disable iff (!resetn)
		bus.wr && bus.addr == ext_irq_pkg::OFF_ENABLE |=> enable_r == $past(bus.wdata))
		else $error("enable write not stored");

	a_enable_hold: assert property (@(posedge clk) disable iff (!resetn)
		!(bus.wr && bus.addr == ext_irq_pkg::OFF_ENABLE) |=> $stable(enable_r))
		else $error("enable changed without a write");

	a_sense_hold: assert property (@(posedge clk) disable iff (!resetn)
		!(bus.wr && bus.addr == ext_irq_pkg::OFF_SENSE_HIGH) |=> $stable(senseHigh_r))
		else $error("high sense changed without a write");

	a_low_hold: assert property (@(posedge clk) disable iff (!resetn)
		!(bus.wr && bus.addr == ext_irq_pkg::OFF_SENSE_LOW) |=> $stable(senseLow_r))
		else $error("low sense changed without a write");

	a_low_write: assert property (@(posedge clk) disable iff (!resetn)
		bus.wr && bus.addr == ext_irq_pkg::OFF_SENSE_LOW |=> senseLow_r == $past(bus.wdata))
		else $error("low sense write not stored");

	// read data stands one cycle only, zero otherwise
	a_enable_read: assert property (@(posedge clk) disable iff (!resetn)
		bus.rd && bus.addr == ext_irq_pkg::OFF_ENABLE |=> rdata == $past(enable_r))
		else $error("enable readback wrong");

	a_read_idle: assert property (@(posedge clk) disable iff (!resetn)
		!bus.rd |=> rdata == '0)
		else $error("read data not zero outside a read");

	a_sense_read: assert property (@(posedge clk) disable iff (!resetn)
		bus.rd && bus.addr == ext_irq_pkg::OFF_SENSE_HIGH |=> rdata == $past(senseHigh_r))
		else $error("high sense readback wrong");

	a_low_read: assert property (@(posedge clk) disable iff (!resetn)
		bus.rd && bus.addr == ext_irq_pkg::OFF_SENSE_LOW |=> rdata == $past(senseLow_r))
		else $error("low sense readback wrong");

	a_flags_read: assert property (@(posedge clk) disable iff (!resetn)
		bus.rd && bus.addr == ext_irq_pkg::OFF_FLAGS |=> rdata[NSRC-1:0] == $past(flags_r))
		else $error("flag readback wrong");

	a_clear_read: assert property (@(posedge clk) disable iff (!resetn)
		bus.rd && bus.addr == ext_irq_pkg::OFF_FLAG_CLEAR |=> rdata == '0)
		else $error("flag clear word not read as zero");

	a_status_read: assert property (@(posedge clk) disable iff (!resetn)
		bus.rd && bus.addr == ext_irq_pkg::OFF_IRQ_STATUS |=> rdata[EW-1:0] == $past(evtStatus_r))
		else $error("event status readback wrong");

	a_evt_en_read: assert property (@(posedge clk) disable iff (!resetn)
		bus.rd && bus.addr == ext_irq_pkg::OFF_IRQ_ENABLE |=> rdata[EW-1:0] == $past(evtEnable_r))
		else $error("event enable readback wrong");

	// pin path: synchroniser plus prev flop puts the edge three samples back
	a_level_low: assert property (@(posedge clk) disable iff (!resetn)
		senseAll[1:0] == 2'h0 && !extReqPinN[0] ##1 senseAll[1:0] == 2'h0 && !extReqPinN[0]
		##1 senseAll[1:0] == 2'h0 |=> flags_r[0])
		else $error("low level did not set flag");

	a_level_src15: assert property (@(posedge clk) disable iff (!resetn)
		senseAll[31:30] == 2'h0 && !extReqPinN[15]
		##1 senseAll[31:30] == 2'h0 && !extReqPinN[15]
		##1 senseAll[31:30] == 2'h0 |=> flags_r[15])
		else $error("source 15 low level did not set flag");

	a_level_src8: assert property (@(posedge clk) disable iff (!resetn)
		senseAll[17:16] == 2'h0 && !extReqPinN[8]
		##1 senseAll[17:16] == 2'h0 && !extReqPinN[8]
		##1 senseAll[17:16] == 2'h0 |=> flags_r[8])
		else $error("source 8 low level did not set flag");

	a_fall_only: assert property (@(posedge clk) disable iff (!resetn)
		hit[0] && senseAll[1:0] == 2'h1 |-> $past(extReqPinN[0], 3) && !$past(extReqPinN[0], 2))
		else $error("falling sense hit without falling edge");

	a_fall_src15: assert property (@(posedge clk) disable iff (!resetn)
		hit[15] && senseAll[31:30] == 2'h1 |-> $past(extReqPinN[15], 3) && !$past(extReqPinN[15], 2))
		else $error("source 15 falling hit without falling edge");

	a_fall_src8: assert property (@(posedge clk) disable iff (!resetn)
		hit[8] && senseAll[17:16] == 2'h1 |-> $past(extReqPinN[8], 3) && !$past(extReqPinN[8], 2))
		else $error("source 8 falling hit without falling edge");

	a_rise_only: assert property (@(posedge clk) disable iff (!resetn)
		hit[0] && senseAll[1:0] == 2'h2 |-> !$past(extReqPinN[0], 3) && $past(extReqPinN[0], 2))
		else $error("rising sense hit without rising edge");

	a_rise_src15: assert property (@(posedge clk) disable iff (!resetn)
		hit[15] && senseAll[31:30] == 2'h2 |-> !$past(extReqPinN[15], 3) && $past(extReqPinN[15], 2))
		else $error("source 15 rising hit without rising edge");

	a_both_edges: assert property (@(posedge clk) disable iff (!resetn)
		hit[0] && senseAll[1:0] == 2'h3 |-> $past(extReqPinN[0], 3) != $past(extReqPinN[0], 2))
		else $error("both-edge hit without transition");

	a_both_src15: assert property (@(posedge clk) disable iff (!resetn)
		hit[15] && senseAll[31:30] == 2'h3 |-> $past(extReqPinN[15], 3) != $past(extReqPinN[15], 2))
		else $error("source 15 both-edge hit without transition");

	// field placement in the joined sense word
	a_high_field: assert property (@(posedge clk) disable iff (!resetn)
		bus.wr && bus.addr == ext_irq_pkg::OFF_SENSE_HIGH
		|=> senseAll[31:30] == $past(bus.wdata[15:14]))
		else $error("source 15 field misplaced");

	a_src9_field: assert property (@(posedge clk) disable iff (!resetn)
		bus.wr && bus.addr == ext_irq_pkg::OFF_SENSE_HIGH |=> senseAll[19:18] == $past(bus.wdata[3:2]))
		else $error("source 9 field misplaced");

	a_src8_field: assert property (@(posedge clk) disable iff (!resetn)
		bus.wr && bus.addr == ext_irq_pkg::OFF_SENSE_HIGH |=> senseAll[17:16] == $past(bus.wdata[1:0]))
		else $error("source 8 field misplaced");

	a_src7_field: assert property (@(posedge clk) disable iff (!resetn)
		bus.wr && bus.addr == ext_irq_pkg::OFF_SENSE_LOW
		|=> senseAll[15:14] == $past(bus.wdata[15:14]))
		else $error("source 7 field misplaced");

	// flags: any hit sets, only a clear without a hit drops
	a_flag_sticky: assert property (@(posedge clk) disable iff (!resetn)
		flags_r[0] && !flagClr[0] |=> flags_r[0])
		else $error("flag dropped without clear");

	a_hit_sets: assert property (@(posedge clk) disable iff (!resetn)
		|hit |=> (flags_r & $past(hit)) == $past(hit))
		else $error("hit did not set its flag");

	a_flag_cause: assert property (@(posedge clk) disable iff (!resetn)
		$rose(flags_r[0]) |-> $past(hit[0]))
		else $error("flag set without a hit");

	a_flag_clear: assert property (@(posedge clk) disable iff (!resetn)
		flags_r[8] && flagClr[8] && !hit[8] |=> !flags_r[8])
		else $error("flag clear did not take");

	// forwarding: a request needs both its flag and its enable
	a_forward_gate: assert property (@(posedge clk) disable iff (!resetn)
		(srcReq & ~flags_r) == '0 && (srcReq & ~$past(enable_r[NSRC-1:0])) == '0)
		else $error("forwarded request without flag and enable");

	a_req_follow: assert property (@(posedge clk) disable iff (!resetn)
		flags_r[15] && $past(enable_r[15]) |-> srcReq[15])
		else $error("enabled flag not forwarded");

	// event interrupt: sticky status, level output while enabled status set
	a_status_sticky: assert property (@(posedge clk) disable iff (!resetn)
		evtStatus_r[ext_irq_pkg::EVT_FLAG_SET] && !evtClr[ext_irq_pkg::EVT_FLAG_SET]
		|=> evtStatus_r[ext_irq_pkg::EVT_FLAG_SET])
		else $error("event status dropped without clear");

	a_overrun_set: assert property (@(posedge clk) disable iff (!resetn)
		|(hit & flags_r & ~flagClr) |=> evtStatus_r[ext_irq_pkg::EVT_OVERRUN])
		else $error("overrun not recorded");

	a_irq_set: assert property (@(posedge clk) disable iff (!resetn)
		|(evtStatus_r & evtEnable_r) && $stable(evtEnable_r) |-> irq)
		else $error("interrupt low with enabled status set");

	a_irq_clear: assert property (@(posedge clk) disable iff (!resetn)
		evtStatus_r == '0 |-> !irq)
		else $error("interrupt high with no status set");
endmodule : ext_irq_enable_sense

// *** core/ext_irq_pkg.sv ***
// package: register map, field layout and sense encodings of the external request block
package ext_irq_pkg;
	localparam int NUM_SRC = 16;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] OFF_ENABLE = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_SENSE_HIGH = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_SENSE_LOW = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_FLAG_CLEAR = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h5;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 4'h6;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 4'h7;
	localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;
	localparam int SENSE_W = 2;
	localparam int SRC_PER_REG = 8;
	localparam int EVT_FLAG_SET = 0;
	localparam int EVT_OVERRUN = 1;
	localparam int EVT_W = 2;

	typedef enum logic [1:0] {
		SENSE_LOW_LEVEL = 2'h0,
		SENSE_FALLING = 2'h1,
		SENSE_RISING = 2'h2,
		SENSE_BOTH = 2'h3
	} sense_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;
endpackage : ext_irq_pkg

// *** test/ext_irq_enable_sense_tb.sv ***
// testbench: register access, sense modes, request gating and event interrupt
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module ext_irq_enable_sense_tb;
	localparam logic [3:0] EN = ext_irq_pkg::OFF_ENABLE;
	localparam logic [3:0] FL = ext_irq_pkg::OFF_FLAGS;
	localparam logic [3:0] FC = ext_irq_pkg::OFF_FLAG_CLEAR;
	localparam logic [3:0] ST = ext_irq_pkg::OFF_IRQ_STATUS;
	localparam logic [3:0] SC = ext_irq_pkg::OFF_IRQ_CLEAR;
	localparam logic [3:0] SE = ext_irq_pkg::OFF_IRQ_ENABLE;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic irq;
	logic [3:0] addr = 4'h0;
	logic [3:0] ra;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] levelN = 16'hFFFF;
	logic [15:0] pinN, rdata, srcReq, b, sw;
	int n_fail = 0;
	int n_tests = 0;
	int src[3] = '{15, 8, 0};
	always #4 clk = ~clk;
	ext_pin_model u_ext_pin_model (.clk(clk), .levelN(levelN), .pinN(pinN));
	ext_irq_enable_sense u_ext_irq_enable_sense (.clk(clk), .resetn(resetn),
		.extReqPinN(pinN), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .srcReq(srcReq), .irq(irq));
	task automatic wrr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wrr
	task automatic rdc(input logic [3:0] a, input logic [15:0] e, input string n);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(n, e, rdata)
	endtask : rdc
	task automatic idle(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : idle
	// pin model, synchroniser and flag need four edges; six leaves margin
	task automatic pin(input int s, input logic v);
		@(posedge clk);
		levelN[s] <= v;
		idle(6);
	endtask : pin
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test
	initial begin
		#200000;
		n_fail++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		rdc(EN, 16'h0000, "enable rst");
		rdc(ext_irq_pkg::OFF_SENSE_HIGH, 16'h0000, "sense hi rst");
		rdc(ext_irq_pkg::OFF_SENSE_LOW, 16'h0000, "sense lo rst");
		wrr(EN, 16'hA5C3);
		rdc(EN, 16'hA5C3, "enable rw");
		rdc(4'hF, 16'h0000, "unmapped");
		rdc(FC, 16'h0000, "clear reads 0");
		$display("register test done");
		for (int i = 0; i < 3; i++) begin
			for (int m = 0; m < 4; m++) begin
				b = 16'h0001 << src[i];
				ra = (src[i] >= 8) ? ext_irq_pkg::OFF_SENSE_HIGH : ext_irq_pkg::OFF_SENSE_LOW;
				sw = 16'(m) << (2 * (src[i] % 8));
				wrr(ra, sw);
				rdc(ra, sw, "sense rw");
				wrr(EN, b);
				wrr(FC, 16'hFFFF);
				rdc(FL, 16'h0000, "flags idle");
				pin(src[i], 1'b0);
				rdc(FL, (m != 2) ? b : 16'h0000, "flags fall");
				`CHK("req fall", (m != 2) ? b : 16'h0000, srcReq)
				wrr(FC, b);
				idle(2);
				rdc(FL, (m == 0) ? b : 16'h0000, "flags low");
				pin(src[i], 1'b1);
				rdc(FL, (m != 1) ? b : 16'h0000, "flags rise");
				wrr(EN, 16'h0000);
				idle(2);
				`CHK("req off", 16'h0000, srcReq)
			end
		end
		$display("sense test done");
		wrr(ext_irq_pkg::OFF_SENSE_HIGH, 16'h0000);
		wrr(ext_irq_pkg::OFF_SENSE_LOW, 16'h0001);
		wrr(FC, 16'hFFFF);
		wrr(SC, 16'h0003);
		wrr(SE, 16'h0001);
		idle(2);
		`CHK("irq idle", 1'b0, irq)
		pin(0, 1'b0);
		`CHK("irq set", 1'b1, irq)
		rdc(ST, 16'h0001, "status");
		wrr(SE, 16'h0000);
		idle(2);
		`CHK("irq masked", 1'b0, irq)
		wrr(SE, 16'h0001);
		idle(2);
		`CHK("irq unmasked", 1'b1, irq)
		wrr(SC, 16'h0001);
		idle(2);
		`CHK("irq cleared", 1'b0, irq)
		rdc(ST, 16'h0000, "status clr");
		rdc(SE, 16'h0001, "irq en rw");
		// flags word is read-only: a write must not disturb the set flag
		wrr(FL, 16'h0000);
		rdc(FL, 16'h0001, "flags ro");
		// second fall while the flag is still set counts as overrun only
		pin(0, 1'b1);
		pin(0, 1'b0);
		rdc(ST, 16'h0002, "overrun");
		`CHK("irq overrun", 1'b0, irq)
		$display("interrupt test done");
		// mid-run reset with pin 0 held low: sense falls back to low level
		@(posedge clk);
		resetn <= 1'b0;
		idle(4);
		@(posedge clk);
		resetn <= 1'b1;
		rdc(EN, 16'h0000, "enable rst2");
		rdc(FL, 16'h0001, "level after rst");
		`CHK("irq rst", 1'b0, irq)
		`CHK("req rst", 16'h0000, srcReq)
		$display("reset test done");
		finish_test();
	end
endmodule : ext_irq_enable_sense_tb

// *** test/ext_pin_model.sv ***
// partner model: the external active-low request pins
`timescale 1ns/10ps
module ext_pin_model (
	input wire logic clk,
	input wire logic [15:0] levelN,
	output logic [15:0] pinN
);
	// pins follow the bench level one edge later, moving just after an edge;
	// the bench level idles high as if pulled up
	always_ff @(posedge clk) begin
		pinN <= levelN;
	end
endmodule : ext_pin_model
